// File: hw/tcc_pkg.sv
// Notes on behaviour
// [R1] Edge bit 0 falling, 1 rising capture
// [R2] Buffer A set: capture C buffers A
// [R3] Buffer B set: capture D buffers B
// [R4] Clock codes 00-10 internal, 11 external rising
// [R5] Capture control clears on reset, low power
// [R6] Compare control loads E0 on reset, low power
// [R7] Compare control top bits read one, fixed
// [R8] Select bit routes shared address to A/B
// [R9] Output A driven only while enable A
// [R10] Output B driven only while enable B
// [R11] Match A drives output A to level A
// [R12] Match B drives output B to level B
// [R13] One shared byte latch for wide registers
// [R14] CPU accesses upper byte then lower byte
// [R15] Upper write latches; lower write commits both
// [R16] Upper read latches lower byte for next read
// [R17] Compare reads bypass the byte latch
// [R18] Internal clocks are divide by 2, 8, 32
// [R19] Outputs stay zero until first match
// [R20] Codes 00, 01, 10 map to 2, 8, 32
package tcc_pkg;
   // Byte addresses on the peripheral bus, upper byte at the even address
   localparam logic [3:0] ADR_CCC = 4'h0;
   localparam logic [3:0] ADR_OCC = 4'h1;
   localparam logic [3:0] ADR_CNT_HI = 4'h2;
   localparam logic [3:0] ADR_CNT_LO = 4'h3;
   localparam logic [3:0] ADR_CMP_HI = 4'h4;
   localparam logic [3:0] ADR_CMP_LO = 4'h5;
   localparam logic [3:0] ADR_CAP_FIRST = 4'h6;
   localparam logic [3:0] ADR_CAP_LAST = 4'hD;
   // Reset values
   localparam logic [7:0] CCC_RST = 8'h00;
   localparam logic [7:0] OCC_RST = 8'hE0;
   localparam logic [7:0] OCC_FIXED = 8'hE0;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [15:0] CMP_RST = 16'hFFFF;
   localparam logic [15:0] CAP_RST = 16'h0000;
   // Field positions of capture_clock_control
   localparam int EDGE_A = 7;
   localparam int BUF_A = 3;
   localparam int BUF_B = 2;
   localparam int CKS_HI = 1;
   localparam int CKS_LO = 0;
   // Field positions of compare_output_control
   localparam int SEL = 4;
   localparam int OE_A = 3;
   localparam int OE_B = 2;
   localparam int LVL_A = 1;
   localparam int LVL_B = 0;
   // Clock select codes and prescaler tap masks
   localparam logic [1:0] CKS_DIV2 = 2'h0;
   localparam logic [1:0] CKS_DIV8 = 2'h1;
   localparam logic [1:0] CKS_DIV32 = 2'h2;
   localparam logic [1:0] CKS_EXT = 2'h3;
   localparam logic [4:0] PRE_DIV2 = 5'h01;
   localparam logic [4:0] PRE_DIV8 = 5'h07;
   localparam logic [4:0] PRE_DIV32 = 5'h1F;
endpackage

// File: hw/tcc_top.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_top (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic low_power,
   input wire logic [3:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_wdata,
   output logic [7:0] bus_rdata,
   input wire logic capture_in_a,
   input wire logic capture_in_b,
   input wire logic capture_in_c,
   input wire logic capture_in_d,
   input wire logic ext_clk,
   output logic compare_out_a,
   output logic compare_out_a_oe_n,
   output logic compare_out_b,
   output logic compare_out_b_oe_n
);
   logic [7:0] ccc_r, ccc_nxt;
   logic [7:0] occ_r, occ_nxt;
   logic [7:0] temp_r, temp_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic [15:0] cmp_a_r, cmp_a_nxt;
   logic [15:0] cmp_b_r, cmp_b_nxt;
   logic [15:0] cap_r [4];
   logic [15:0] cap_nxt [4];
   logic [4:0] pre_r, pre_nxt;
   logic [3:0] cin, cin_prev_r, cap_ev;
   logic ext_prev_r;
   logic out_a_r, out_a_nxt, out_b_r, out_b_nxt;
   logic oe_a_n_r, oe_b_n_r;
   logic cnt_tick, match_a, match_b;
   logic [3:0] cap_off;
   logic [1:0] cap_idx;
   logic is_cap;

   assign cin = {capture_in_d, capture_in_c, capture_in_b, capture_in_a};
   assign bus_rdata = rdata_r;
   assign compare_out_a = out_a_r;
   assign compare_out_b = out_b_r;
   assign compare_out_a_oe_n = oe_a_n_r;
   assign compare_out_b_oe_n = oe_b_n_r;

   // Edge detect per capture pin, polarity from its own select bit
   for (genvar i = 0; i < 4; i++) begin : g_edge
      assign cap_ev[i] = ccc_r[tcc_pkg::EDGE_A - i] ?
         (cin[i] & ~cin_prev_r[i]) : (~cin[i] & cin_prev_r[i]); // [R1]
   end

   // Counter clock enable; prescaler runs free so the divided rates stay in phase
   always_comb begin
      case (ccc_r[tcc_pkg::CKS_HI:tcc_pkg::CKS_LO])
         tcc_pkg::CKS_DIV2: begin
            cnt_tick = (pre_r & tcc_pkg::PRE_DIV2) == tcc_pkg::PRE_DIV2; // [R18] [R20]
         end
         tcc_pkg::CKS_DIV8: begin
            cnt_tick = (pre_r & tcc_pkg::PRE_DIV8) == tcc_pkg::PRE_DIV8; // [R18] [R20]
         end
         tcc_pkg::CKS_DIV32: begin
            cnt_tick = (pre_r & tcc_pkg::PRE_DIV32) == tcc_pkg::PRE_DIV32; // [R18] [R20]
         end
         default: begin
            cnt_tick = ext_clk & ~ext_prev_r; // [R4]
         end
      endcase
   end

   // Match fires on the tick that moves the counter off the matching value
   assign match_a = cnt_tick && (cnt_r == cmp_a_r);
   assign match_b = cnt_tick && (cnt_r == cmp_b_r);

   // Capture register index for the bus address
   assign cap_off = bus_addr - tcc_pkg::ADR_CAP_FIRST;
   assign cap_idx = cap_off[2:1];
   assign is_cap = (bus_addr >= tcc_pkg::ADR_CAP_FIRST) && (bus_addr <= tcc_pkg::ADR_CAP_LAST);

   // Next state of the timer except pin enables and edge history; bus access, capture, compare, low power
   always_comb begin
      ccc_nxt = ccc_r;
      occ_nxt = occ_r;
      temp_nxt = temp_r;
      rdata_nxt = rdata_r;
      cmp_a_nxt = cmp_a_r;
      cmp_b_nxt = cmp_b_r;
      cap_nxt = cap_r;
      pre_nxt = pre_r + 5'h01;
      out_a_nxt = out_a_r;
      out_b_nxt = out_b_r;
      cnt_nxt = cnt_tick ? cnt_r + 16'h0001 : cnt_r;
      // Compare outputs move on a match or to zero in low power; zero until the first match
      if (match_a) begin
         out_a_nxt = occ_r[tcc_pkg::LVL_A]; // [R11] [R19]
      end
      if (match_b) begin
         out_b_nxt = occ_r[tcc_pkg::LVL_B]; // [R12] [R19]
      end
      // Pair A: with buffering the old A value moves into C
      if (cap_ev[0]) begin
         if (ccc_r[tcc_pkg::BUF_A]) begin
            cap_nxt[2] = cap_r[0]; // [R2]
         end
         cap_nxt[0] = cnt_r;
      end
      if (cap_ev[2] && !ccc_r[tcc_pkg::BUF_A]) begin
         cap_nxt[2] = cnt_r; // [R2]
      end
      // Pair B mirrors pair A with D as the buffer
      if (cap_ev[1]) begin
         if (ccc_r[tcc_pkg::BUF_B]) begin
            cap_nxt[3] = cap_r[1]; // [R3]
         end
         cap_nxt[1] = cnt_r;
      end
      if (cap_ev[3] && !ccc_r[tcc_pkg::BUF_B]) begin
         cap_nxt[3] = cnt_r; // [R3]
      end
      // Bus write; a counter write beats a tick in the same cycle
      if (bus_wr) begin
         if (bus_addr == tcc_pkg::ADR_CCC) begin
            ccc_nxt = bus_wdata;
         end else if (bus_addr == tcc_pkg::ADR_OCC) begin
            occ_nxt = tcc_pkg::OCC_FIXED | bus_wdata; // [R7]
         end else if (bus_addr == tcc_pkg::ADR_CNT_LO) begin
            cnt_nxt = {temp_r, bus_wdata}; // [R15]
         end else if (bus_addr == tcc_pkg::ADR_CMP_LO) begin
            if (occ_r[tcc_pkg::SEL]) begin
               cmp_b_nxt = {temp_r, bus_wdata}; // [R8] [R15]
            end else begin
               cmp_a_nxt = {temp_r, bus_wdata}; // [R8] [R15]
            end
         end else if (bus_addr == tcc_pkg::ADR_CNT_HI || bus_addr == tcc_pkg::ADR_CMP_HI
                      || (is_cap && !bus_addr[0])) begin
            temp_nxt = bus_wdata; // [R13] [R15]
         end
      end else if (bus_rd) begin
         // Bus read; capture lower bytes are read-only and writes fall through
         if (bus_addr == tcc_pkg::ADR_CCC) begin
            rdata_nxt = ccc_r;
         end else if (bus_addr == tcc_pkg::ADR_OCC) begin
            rdata_nxt = occ_r; // [R7]
         end else if (bus_addr == tcc_pkg::ADR_CNT_HI) begin
            rdata_nxt = cnt_r[15:8];
            temp_nxt = cnt_r[7:0]; // [R16]
         end else if (bus_addr == tcc_pkg::ADR_CNT_LO) begin
            rdata_nxt = temp_r; // [R16]
         end else if (bus_addr == tcc_pkg::ADR_CMP_HI) begin
            rdata_nxt = occ_r[tcc_pkg::SEL] ? cmp_b_r[15:8] : cmp_a_r[15:8]; // [R8] [R17]
         end else if (bus_addr == tcc_pkg::ADR_CMP_LO) begin
            rdata_nxt = occ_r[tcc_pkg::SEL] ? cmp_b_r[7:0] : cmp_a_r[7:0]; // [R8] [R17]
         end else if (is_cap && !bus_addr[0]) begin
            rdata_nxt = cap_r[cap_idx][15:8];
            temp_nxt = cap_r[cap_idx][7:0]; // [R13] [R16]
         end else if (is_cap) begin
            rdata_nxt = temp_r; // [R16]
         end else begin
            rdata_nxt = 8'h00;
         end
      end
      // Low-power modes hold control, counter, compare, capture and outputs at reset; prescaler and byte latch keep running
      if (low_power) begin
         ccc_nxt = tcc_pkg::CCC_RST; // [R5]
         occ_nxt = tcc_pkg::OCC_RST; // [R6]
         cnt_nxt = tcc_pkg::CNT_RST;
         cmp_a_nxt = tcc_pkg::CMP_RST;
         cmp_b_nxt = tcc_pkg::CMP_RST;
         for (int k = 0; k < 4; k++) begin
            cap_nxt[k] = tcc_pkg::CAP_RST;
         end
         out_a_nxt = 1'b0;
         out_b_nxt = 1'b0;
      end
   end

   // State registers; pin enables follow the control bits one cycle late
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         ccc_r <= tcc_pkg::CCC_RST; // [R5]
         occ_r <= tcc_pkg::OCC_RST; // [R6]
         temp_r <= 8'h00;
         rdata_r <= 8'h00;
         cnt_r <= tcc_pkg::CNT_RST;
         cmp_a_r <= tcc_pkg::CMP_RST;
         cmp_b_r <= tcc_pkg::CMP_RST;
         for (int k = 0; k < 4; k++) begin
            cap_r[k] <= tcc_pkg::CAP_RST;
         end
         pre_r <= 5'h00;
         cin_prev_r <= 4'h0;
         ext_prev_r <= 1'b0;
         out_a_r <= 1'b0; // [R19]
         out_b_r <= 1'b0; // [R19]
         oe_a_n_r <= 1'b1;
         oe_b_n_r <= 1'b1;
      end else begin
         ccc_r <= ccc_nxt;
         occ_r <= occ_nxt;
         temp_r <= temp_nxt;
         rdata_r <= rdata_nxt;
         cnt_r <= cnt_nxt;
         cmp_a_r <= cmp_a_nxt;
         cmp_b_r <= cmp_b_nxt;
         cap_r <= cap_nxt;
         pre_r <= pre_nxt;
         cin_prev_r <= cin;
         ext_prev_r <= ext_clk;
         out_a_r <= out_a_nxt;
         out_b_r <= out_b_nxt;
         oe_a_n_r <= ~occ_r[tcc_pkg::OE_A]; // [R9]
         oe_b_n_r <= ~occ_r[tcc_pkg::OE_B]; // [R10]
      end
   end

   // Helpers seen only by the checks below
   logic [7:0] cnt_lo;
   logic [15:0] wr_word;
   logic rd_cnt_hi, rd_cnt_lo, sel8, sel_ext;
   assign cnt_lo = cnt_r[7:0];
   assign wr_word = {temp_r, bus_wdata};
   assign rd_cnt_hi = bus_rd && !bus_wr && !low_power && bus_addr == tcc_pkg::ADR_CNT_HI;
   assign rd_cnt_lo = bus_rd && !bus_wr && !low_power && bus_addr == tcc_pkg::ADR_CNT_LO;
   assign sel8 = ccc_r[1:0] == tcc_pkg::CKS_DIV8;
   assign sel_ext = ccc_r[1:0] == tcc_pkg::CKS_EXT;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);

   a_edge_capture: assert property (cap_ev[0] && !low_power |=> cap_r[0] == $past(cnt_r)) // [R1]
      else $error("capture A missed counter value");
   a_buffer_pair_a: assert property (cap_ev[0] && ccc_r[3] && !low_power
      |=> cap_r[2] == $past(cap_r[0])) // [R2]
      else $error("buffer C did not take old A");
   a_buffer_pair_b: assert property (cap_ev[1] && ccc_r[2] && !low_power
      |=> cap_r[3] == $past(cap_r[1])) // [R3]
      else $error("buffer D did not take old B");
   a_ext_count: assert property (sel_ext && ext_clk && !ext_prev_r && !low_power && !bus_wr
      |=> cnt_r == 16'($past(cnt_r) + 16'h0001)) // [R4]
      else $error("external edge not counted");
   a_div8_period: assert property ((sel8 && cnt_tick && !bus_wr) ##1 (sel8 && !bus_wr)[*8]
      |-> cnt_tick) // [R18]
      else $error("divide by 8 period wrong");
   a_ctrl_lowpow: assert property (low_power |=> ccc_r == 8'h00 ##1 1'b1) // [R5]
      else $error("capture control not cleared");
   a_occ_lowpow: assert property (low_power |=> occ_r == 8'hE0) // [R6]
      else $error("compare control not at E0");
   a_occ_reserved: assert property (bus_rd && !bus_wr && bus_addr == tcc_pkg::ADR_OCC
      |=> bus_rdata[7:5] == 3'h7) // [R7]
      else $error("reserved bits not one");
   a_cmp_select: assert property (bus_wr && bus_addr == tcc_pkg::ADR_CMP_LO && occ_r[4]
      && !low_power |=> cmp_b_r == $past(wr_word) && $stable(cmp_a_r)) // [R8]
      else $error("shared address misrouted");
   a_oe_a_gate: assert property (!occ_r[3] |=> compare_out_a_oe_n) // [R9]
      else $error("output A driven while disabled");
   a_oe_b_gate: assert property (!occ_r[2] |=> compare_out_b_oe_n) // [R10]
      else $error("output B driven while disabled");
   a_match_lvl_a: assert property (match_a && !low_power
      |=> compare_out_a == $past(occ_r[1])) // [R11]
      else $error("output A level wrong after match");
   a_match_lvl_b: assert property (match_b && !low_power
      |=> compare_out_b == $past(occ_r[0])) // [R12]
      else $error("output B level wrong after match");
   a_read_pair: assert property (rd_cnt_hi ##1 (!bus_wr && !bus_rd) ##1 rd_cnt_lo
      |=> bus_rdata == $past(cnt_lo, 3)) // [R16]
      else $error("lower byte not from latch");
   a_cmp_direct: assert property (bus_rd && !bus_wr && bus_addr == tcc_pkg::ADR_CMP_LO
      && !occ_r[4] |=> bus_rdata == $past(cmp_a_r[7:0]) && $stable(temp_r)) // [R17]
      else $error("compare read used latch");
   a_oe_a_on: assert property (occ_r[3] |=> !compare_out_a_oe_n) // [R9]
      else $error("output A not driven while enabled");
   a_oe_b_on: assert property (occ_r[2] |=> !compare_out_b_oe_n) // [R10]
      else $error("output B not driven while enabled");
   a_cnt_commit: assert property (bus_wr && bus_addr == tcc_pkg::ADR_CNT_LO && !low_power
      |=> cnt_r == $past(wr_word)) // [R15]
      else $error("counter word not committed");
   a_hi_latch_only: assert property (bus_wr && bus_addr == tcc_pkg::ADR_CNT_HI && !cnt_tick
      && !low_power |=> temp_r == $past(bus_wdata) && $stable(cnt_r)) // [R15]
      else $error("upper write touched counter");
   a_capture_c_free: assert property (cap_ev[2] && !ccc_r[3] && !low_power
      |=> cap_r[2] == $past(cnt_r)) // [R2]
      else $error("capture C missed counter value");
   a_buffer_c_hold: assert property (ccc_r[3] && !cap_ev[0] && !low_power
      |=> $stable(cap_r[2])) // [R2]
      else $error("buffer C changed without A capture");
   a_div2_period: assert property ((ccc_r[1:0] == tcc_pkg::CKS_DIV2) ##1
      (ccc_r[1:0] == tcc_pkg::CKS_DIV2) |-> cnt_tick != $past(cnt_tick)) // [R18] [R20]
      else $error("divide by 2 period wrong");
   a_cap_read_latch: assert property (bus_rd && !bus_wr && bus_addr == tcc_pkg::ADR_CAP_FIRST
      |=> temp_r == $past(cap_r[0][7:0])) // [R16]
      else $error("capture lower byte not latched");

   c_capture_a: cover property (cap_ev[0] && !low_power);
   c_buffered: cover property (cap_ev[0] && ccc_r[3]);
   c_match_a_high: cover property (match_a && occ_r[1] && occ_r[3]);
   c_word_write: cover property (bus_wr && bus_addr == tcc_pkg::ADR_CMP_HI
      ##2 bus_wr && bus_addr == tcc_pkg::ADR_CMP_LO);
   c_buffered_b: cover property (cap_ev[1] && ccc_r[2]);
endmodule
`default_nettype wire

// File: tb/tcc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// Byte-wide peripheral bus master standing in for the processor
module tcc_cpu_model (
   input wire logic core_clk,
   output logic [3:0] bus_addr,
   output logic bus_wr,
   output logic bus_rd,
   output logic [7:0] bus_wdata,
   input wire logic [7:0] bus_rdata
);
   initial begin
      bus_addr = 4'h0;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_wdata = 8'h00;
   end
   // One byte per strobe; launched just after an edge, dropped after the taking edge
   task automatic wr8(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #1;
      bus_addr = a;
      bus_wdata = d;
      bus_wr = 1'b1;
      @(posedge core_clk);
      #1;
      bus_wr = 1'b0;
      bus_wdata = ~d; // Idle data lines must not look like the last byte
   endtask
   // Read data is registered, so it is settled just after the taking edge
   task automatic rd8(input logic [3:0] a, output logic [7:0] d);
      @(posedge core_clk);
      #1;
      bus_addr = a;
      bus_rd = 1'b1;
      @(posedge core_clk);
      #1;
      bus_rd = 1'b0;
      d = bus_rdata;
   endtask
   // Wide registers are always a pair, upper byte first
   task automatic wr16(input logic [3:0] a, input logic [15:0] v);
      wr8(a, v[15:8]);
      wr8(a + 4'h1, v[7:0]);
   endtask
   task automatic rd16(input logic [3:0] a, output logic [15:0] v);
      rd8(a, v[15:8]);
      rd8(a + 4'h1, v[7:0]);
   endtask
endmodule
`default_nettype wire

// File: tb/test_timer_capture_compare_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_timer_capture_compare_control;
   localparam logic [3:0] CCC = tcc_pkg::ADR_CCC;
   localparam logic [3:0] OCC = tcc_pkg::ADR_OCC;
   localparam logic [3:0] CNT = tcc_pkg::ADR_CNT_HI;
   localparam logic [3:0] CMP = tcc_pkg::ADR_CMP_HI;
   typedef struct packed {logic [3:0] a; logic [7:0] d; logic [7:0] e;} tcc_row_s;
   logic core_clk, nrst, low_power, ext_clk, bus_wr, bus_rd;
   logic oa, oa_n, ob, ob_n;
   logic [3:0] cap_in, bus_addr;
   logic [7:0] bus_wdata, bus_rdata, b;
   logic [15:0] v, w;
   int err_count = 0;
   int total_checks = 0;
   // Address, byte written, byte expected back; top bits of OCC stay set
   tcc_row_s rows [6] = '{'{CCC, 8'hA5, 8'hA5}, '{OCC, 8'h00, 8'hE0}, '{OCC, 8'h1F, 8'hFF},
      '{OCC, 8'h0A, 8'hEA}, '{4'hE, 8'h77, 8'h00}, '{4'hF, 8'h77, 8'h00}};

   tcc_top dut_u (.core_clk(core_clk), .nrst(nrst), .low_power(low_power),
      .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
      .bus_rdata(bus_rdata), .capture_in_a(cap_in[0]), .capture_in_b(cap_in[1]),
      .capture_in_c(cap_in[2]), .capture_in_d(cap_in[3]), .ext_clk(ext_clk),
      .compare_out_a(oa), .compare_out_a_oe_n(oa_n), .compare_out_b(ob),
      .compare_out_b_oe_n(ob_n));
   tcc_cpu_model cpu_u (.core_clk(core_clk), .bus_addr(bus_addr), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));

   always #20 core_clk = ~core_clk;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Pins as one nibble: out_a, out_b, oe_n_a, oe_n_b
   function automatic logic [15:0] pins();
      return {12'h000, oa, ob, oa_n, ob_n};
   endfunction
   // External edges are held several cycles so the edge detector cannot miss them
   task automatic ext_pulse();
      repeat (3) @(posedge core_clk);
      #1 ext_clk = 1'b1;
      repeat (3) @(posedge core_clk);
      #1 ext_clk = 1'b0;
   endtask
   // Rewind the frozen counter to one below the compare value, then match
   task automatic match(input logic [7:0] ctl, input logic [15:0] exp);
      cpu_u.wr8(OCC, ctl);
      cpu_u.wr16(CNT, 16'h000F);
      ext_pulse();
      ext_pulse();
      repeat (3) @(posedge core_clk);
      #1;
      check(pins(), exp);
   endtask
   // Rise then fall on all capture pins at known counts, then read all four
   task automatic cap_round(input logic [7:0] ctl, input logic [15:0] e [4]);
      logic [15:0] c;
      cpu_u.wr8(CCC, ctl);
      for (int k = 0; k < 2; k++) begin
         cpu_u.wr16(CNT, e[k]);
         @(posedge core_clk);
         #1 cap_in = ~cap_in;
         repeat (3) @(posedge core_clk);
      end
      for (int k = 0; k < 4; k++) begin
         cpu_u.rd16(tcc_pkg::ADR_CAP_FIRST + 4'(2 * k), c);
         check(c, e[k]);
      end
   endtask

   // Hang guard; the full run needs far fewer cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      finish_test();
   end

   initial begin
      core_clk = 1'b0;
      nrst = 1'b0;
      low_power = 1'b0;
      ext_clk = 1'b0;
      cap_in = 4'h0;
      repeat (20) @(posedge core_clk);
      #1 nrst = 1'b1;
      cpu_u.rd8(CCC, b);
      check({8'h00, b}, 16'h0000);
      check(pins(), 16'h0003);
      foreach (rows[i]) begin
         cpu_u.wr8(rows[i].a, rows[i].d);
         cpu_u.rd8(rows[i].a, b);
         check({8'h00, b}, {8'h00, rows[i].e});
      end
      $display("register table done");
      // Shared address, selected by the select bit
      cpu_u.wr8(OCC, 8'h00);
      cpu_u.wr16(CMP, 16'h1234);
      cpu_u.wr8(OCC, 8'h10);
      cpu_u.wr16(CMP, 16'h5678);
      cpu_u.rd16(CMP, v);
      check(v, 16'h5678);
      cpu_u.wr8(OCC, 8'h00);
      cpu_u.rd16(CMP, v);
      check(v, 16'h1234);
      $display("compare select done");
      // Frozen counter: compare reads bypass the latch, compare writes share it
      cpu_u.wr8(CCC, 8'h03);
      cpu_u.wr16(CNT, 16'hAA55);
      cpu_u.rd8(CNT, b);
      check({8'h00, b}, 16'h00AA);
      cpu_u.rd8(CMP, b);
      check({8'h00, b}, 16'h0012);
      cpu_u.rd8(CNT + 4'h1, b);
      check({8'h00, b}, 16'h0055);
      cpu_u.rd8(CNT, b);
      cpu_u.wr8(CMP, 8'h99);
      cpu_u.rd8(CNT + 4'h1, b);
      check({8'h00, b}, 16'h0099);
      cpu_u.wr16(CNT, 16'h0000);
      repeat (5) ext_pulse();
      cpu_u.rd16(CNT, v);
      check(v, 16'h0005);
      $display("byte latch and external clock done");
      // Upper-byte reads 64 cycles apart see exactly 64 / divisor ticks
      for (int i = 0; i < 3; i++) begin
         cpu_u.wr8(CCC, {6'h00, i[1:0]});
         cpu_u.rd16(CNT, v);
         repeat (60) @(posedge core_clk);
         cpu_u.rd16(CNT, w);
         check(w - v, 16'h0040 >> (2 * i + 1));
      end
      $display("internal clocks done");
      cpu_u.wr8(CCC, 8'h03);
      cpu_u.wr16(CMP, 16'h0010);
      cpu_u.wr8(OCC, 8'h10);
      cpu_u.wr16(CMP, 16'h0010);
      match(8'h1C, 16'h0000);
      match(8'h1F, 16'h000C);
      cpu_u.wr8(OCC, 8'h13);
      repeat (2) @(posedge core_clk);
      #1;
      check(pins(), 16'h000F);
      @(posedge core_clk);
      #1 nrst = 1'b0;
      repeat (2) @(posedge core_clk);
      #1 nrst = 1'b1;
      check(pins(), 16'h0003);
      cpu_u.rd8(OCC, b);
      check({8'h00, b}, 16'h00E0);
      $display("compare outputs done");
      cap_round(8'hA3, '{16'h1111, 16'h2222, 16'h1111, 16'h2222});
      cap_round(8'hAF, '{16'h3333, 16'h4444, 16'h1111, 16'h2222});
      $display("capture done");
      cpu_u.wr8(OCC, 8'h1F);
      @(posedge core_clk);
      #1 low_power = 1'b1;
      @(posedge core_clk);
      #1 low_power = 1'b0;
      cpu_u.rd8(CCC, b);
      check({8'h00, b}, 16'h0000);
      cpu_u.rd8(OCC, b);
      check({8'h00, b}, 16'h00E0);
      $display("low power done");
      finish_test();
   end
endmodule
`default_nettype wire
